// *** amp_tdm_consts.svh ***
// Purpose: shared offsets, field positions, reset values and timing counts
// Assumes: 50 MHz system clock
// Notes: definitions only
`ifndef AMP_TDM_CONSTS_SVH
`define AMP_TDM_CONSTS_SVH

// ********************
// register offsets
// ********************
`define REG_FIRST 8'h05
`define REG_DCBLK 8'h05
`define REG_PROT 8'h06
`define REG_SHDN 8'h07
`define REG_FRAME 8'h08
`define REG_RXFRM 8'h09
`define REG_RXFMT 8'h0a
`define REG_LIMIT 8'h0b
`define REG_SLOTS 8'h0c

// ********************
// reset values and write masks
// ********************
`define RST_DCBLK 8'h41
`define RST_PROT 8'h00
`define RST_SHDN 8'h20
`define RST_FRAME 8'h09
`define RST_RXFRM 8'h02
`define RST_RXFMT 8'h0a
`define RST_LIMIT 8'h80
`define RST_SLOTS 8'h10
`define WMASK_RXFRM 8'h7f
`define WMASK_LIMIT 8'hf0
`define WMASK_SHDN 8'hfe

// ********************
// field positions (lsb of each field) and the 96 kHz rate code
// ********************
`define F_HPF 0
`define F_TFB 3
`define F_OVERCURRENT_RETRY 5
`define F_OVERTEMP_RETRY 4
`define F_PFFB 3
`define F_SAFE 2
`define F_OCTH 0
`define F_SHUTDOWN_PIN_BEHAVIOUR 6
`define F_SDZ_TIME 4
`define F_RAMP 2
`define F_GBL 1
`define F_REDET 0
`define F_INV 7
`define F_SYNC 6
`define F_FAM 5
`define F_AUTO_OFF 4
`define F_RATE 1
`define F_FSTART 0
`define F_JUST 6
`define F_OFFSET 1
`define F_EDGE 0
`define F_SENSE 6
`define F_POLICY 4
`define F_WLEN 2
`define F_SLEN 0
`define F_LIM 4
`define F_SLOT_R 4
`define F_SLOT_L 0
`define RATE_96K 3'h5

// ********************
// timing
// ********************
`define CLK_HZ 50000000
`define CLK_PERIOD_NS 20
`define BCLK_PERIOD_NS 160
`define SHDN_T0_US 2000
`define SHDN_T1_US 4000
`define SHDN_T2_US 6000
`define SHDN_T3_US 23800
`define RETRY_MS 100
`define RATE_SPLIT_HZ 72000
`define HPF_SCALE_NUM 941
`define HPF_SCALE_SHIFT 10

`endif

// *** amp_tdm_dev.sv ***
// Purpose: amplifier configuration bank and serial audio receiver
// Assumes: link pins asynchronous, sampled by clk_sys at 50 MHz
// Notes: register port is a plain write strobe plus registered read
// Overview of operation
// - record dc cutoff code maps to hertz
// - over-current retry after timer when enabled
// - over-temperature retry after timer when enabled
// - feedback source: outputs or sense pins
// - safe mode adds 18 dB attenuation
// - over-current threshold nominal or lowered 10-30%
// - shutdown pin: timed or immediate shutdown
// - volume ramps 0.5 dB per 1/4/8 samples
// - address re-detect bit pulses, then self-clears
// - output invert flips amplifier polarity
// - switching lock overrides spread spectrum
// - rate family bit picks 48 or 44.1
// - rate auto-detected unless detection disabled
// - programmed rate: 100b single, 101b double
// - frame starts on selected sync edge
// - sample left or right justified in slot
// - slot 0 begins offset cycles after sync
// - data captured on selected bit-clock edge
// - sense data truncated to 16/12/8 bits
// - slot policy: address, left, right, downmix
// - word and slot lengths from codes
// - right slot upper nibble, left lower
`timescale 1ns/1ns
`default_nettype none
`include "amp_tdm_consts.svh"
module amp_tdm_dev #(
  parameter int SHDN_CYC0 = `SHDN_T0_US * (`CLK_HZ / 1000000),
  parameter int SHDN_CYC1 = `SHDN_T1_US * (`CLK_HZ / 1000000),
  parameter int SHDN_CYC2 = `SHDN_T2_US * (`CLK_HZ / 1000000),
  parameter int SHDN_CYC3 = `SHDN_T3_US * (`CLK_HZ / 1000000),
  parameter int RETRY_CYC = `RETRY_MS * (`CLK_HZ / 1000)
) (
  input wire logic clk_sys, // system clock
  input wire logic rst_b, // async reset, active low
  tdm_link_if.dev link, // serial audio from host
  input wire logic cfg_wr, // register write strobe
  input wire logic [7:0] cfg_addr, // register offset
  input wire logic [7:0] cfg_wdata, // write data
  output logic [7:0] cfg_rdata, // read data, one cycle after address
  input wire logic shutdown_pin_b, // shutdown pin, low asserts
  input wire logic oc_event, // over-current pulse
  input wire logic ot_event, // over-temperature pulse
  input wire logic spread_req, // spread spectrum requested
  input wire logic [7:0] target_volume, // volume goal, 0.5 dB units
  input wire logic [15:0] sense_in, // raw sense sample
  input wire logic [3:0] addr_offset, // slot from bus address
  output amp_tdm_pkg::sample_t audio, // selected sample
  output logic audio_valid, // pulse per frame
  output logic rate_double, // 88.2/96 family in use
  output logic amp_shutdown, // amplifier shut down
  output logic oc_fault, // over-current hold-off
  output logic ot_fault, // over-temperature hold-off
  output logic [7:0] volume, // ramped volume
  output logic [15:0] sense_out, // formatted sense
  output logic [9:0] hpf_hz, // record cutoff, 0 bypass
  output logic thermal_foldback_on, // foldback enable
  output logic feedback_from_sense, // feedback from sense pins
  output logic extra_atten_18db, // safe attenuation on
  output logic [4:0] oc_threshold_pct, // percent below nominal
  output logic output_invert, // polarity flip
  output logic switching_lock, // lock to audio clocks
  output logic spread_active, // spread spectrum running
  output logic rate_base_44k, // locked base is 44.1 kHz
  output logic addr_redetect, // re-detect pulse
  output logic global_addr_on, // global address enable
  output logic [3:0] limiter_max_atten // limiter code
);
  localparam int NREG = 8;
  localparam int I_DCB = `REG_DCBLK - `REG_FIRST;
  localparam int I_PROT = `REG_PROT - `REG_FIRST;
  localparam int I_SHDN = `REG_SHDN - `REG_FIRST;
  localparam int I_FRM = `REG_FRAME - `REG_FIRST;
  localparam int I_RXF = `REG_RXFRM - `REG_FIRST;
  localparam int I_FMT = `REG_RXFMT - `REG_FIRST;
  localparam int I_LIM = `REG_LIMIT - `REG_FIRST;
  localparam int I_SLT = `REG_SLOTS - `REG_FIRST;
  localparam logic [15:0] RATE_SPLIT = 16'(`CLK_HZ / `RATE_SPLIT_HZ);

  typedef struct packed {
    logic [NREG-1:0][7:0] regs;
    logic [7:0] rdata;
    logic redetect;
    logic bclk_prev;
    logic fs_prev;
    logic in_frame;
    logic [4:0] pre;
    logic [4:0] slot;
    logic [5:0] bitc;
    logic [31:0] shreg;
    amp_tdm_pkg::sample_t left;
    amp_tdm_pkg::sample_t right;
    amp_tdm_pkg::sample_t mono;
    amp_tdm_pkg::sample_t audio;
    logic audio_valid;
    logic [15:0] period;
    logic double_det;
    logic rate_double;
    logic [20:0] shdn_cnt;
    logic shutdown;
    logic [1:0] fault;
    logic [1:0][22:0] retry_cnt;
    logic [2:0] ramp_cnt;
    logic [7:0] volume;
    logic [15:0] sense;
    logic [9:0] hpf;
    logic spread;
  } dev_s;
  dev_s s_q;
  dev_s s_d;
  logic [3:0] syn;

  initial
  begin
    if (SHDN_CYC3 >= (1 << 21) || SHDN_CYC0 < 1)
      $error("shutdown counts do not fit the timer");
    if (RETRY_CYC >= (1 << 23) || RETRY_CYC < 1)
      $error("retry count does not fit the timer");
  end

  // ********************
  // pin synchroniser
  // ********************
  // shutdown pin resets high so reset does not look like an assertion
  pin_sync #(.W(4), .INIT(4'h8)) u_sync (
    .clk_sys(clk_sys),
    .rst_b(rst_b),
    .din({shutdown_pin_b, link.serial_data, link.frame_sync, link.serial_bit_clock}),
    .dout(syn)
  );

  // write mask per register, read-only reserved bits stay zero
  function automatic logic [7:0] wmask(input int i);
    case (i)
      I_RXF: wmask = `WMASK_RXFRM;
      I_LIM: wmask = `WMASK_LIMIT;
      I_SHDN: wmask = `WMASK_SHDN;
      default: wmask = 8'hff;
    endcase
  endfunction

  // shutdown grace time by code
  function automatic logic [20:0] shdn_limit(input logic [1:0] c);
    case (c)
      2'h0: shdn_limit = 21'(SHDN_CYC0 - 1);
      2'h1: shdn_limit = 21'(SHDN_CYC1 - 1);
      2'h2: shdn_limit = 21'(SHDN_CYC2 - 1);
      default: shdn_limit = 21'(SHDN_CYC3 - 1);
    endcase
  endfunction

  // ********************
  // next state
  // ********************
  logic [NREG-1:0][7:0] r;
  logic [7:0] idx;
  logic cap;
  logic start;
  logic [5:0] sl;
  logic [5:0] wl;
  logic [5:0] st;
  logic [4:0] pre_v;
  logic [4:0] slot_v;
  logic [5:0] bit_v;
  logic [31:0] sh_v;
  logic [31:0] word;
  logic [32:0] mix;
  logic [1:0] tick;
  logic [2:0] ramp_top;
  logic [9:0] hz;
  logic [19:0] hz_scaled;
  logic [1:0] retry_on;

  always_comb
  begin
    s_d = s_q;
    r = s_q.regs;
    idx = cfg_addr - `REG_FIRST;
    s_d.redetect = 1'b0;
    s_d.audio_valid = 1'b0;
    // register port: masked write, read of the addressed register
    if (cfg_wr && cfg_addr >= `REG_FIRST && idx < 8'(NREG))
      s_d.regs[idx[2:0]] = cfg_wdata & wmask(int'(idx));
    if (cfg_wr && cfg_addr == `REG_SHDN && cfg_wdata[`F_REDET])
      s_d.redetect = 1'b1;
    s_d.rdata = (cfg_addr >= `REG_FIRST && idx < 8'(NREG)) ? r[idx[2:0]] : 8'h00;

    // receiver framing
    cap = r[I_RXF][`F_EDGE] ? (~syn[0] & s_q.bclk_prev) : (syn[0] & ~s_q.bclk_prev);
    s_d.bclk_prev = syn[0];
    start = cap & (syn[1] ^ r[I_FRM][`F_FSTART]) & ~(s_q.fs_prev ^ r[I_FRM][`F_FSTART]);
    sl = amp_tdm_pkg::slot_bits(r[I_FMT][`F_SLEN +: 2]);
    wl = amp_tdm_pkg::word_bits(r[I_FMT][`F_WLEN +: 2]);
    if (wl > sl)
      wl = sl;
    st = r[I_RXF][`F_JUST] ? 6'(sl - wl) : 6'h00;
    pre_v = start ? r[I_RXF][`F_OFFSET +: 5] : s_q.pre;
    slot_v = start ? 5'h00 : s_q.slot;
    bit_v = start ? 6'h00 : s_q.bitc;
    sh_v = s_q.shreg;
    word = 32'h0;
    if (cap)
      s_d.fs_prev = syn[1];
    if (start)
    begin
      s_d.in_frame = 1'b1;
      s_d.audio_valid = 1'b1;
      mix = {s_q.left[31], s_q.left} + {s_q.right[31], s_q.right};
      unique case (amp_tdm_pkg::slot_policy_e'(r[I_FMT][`F_POLICY +: 2]))
        amp_tdm_pkg::POL_ADDR: s_d.audio = s_q.mono;
        amp_tdm_pkg::POL_LEFT: s_d.audio = s_q.left;
        amp_tdm_pkg::POL_RIGHT: s_d.audio = s_q.right;
        amp_tdm_pkg::POL_MIX: s_d.audio = mix[32:1];
      endcase
      s_d.double_det = s_q.period < RATE_SPLIT;
      s_d.period = 16'h0000;
    end
    else
    begin
      mix = 33'h0;
      s_d.period = (s_q.period == 16'hffff) ? s_q.period : s_q.period + 16'h0001;
    end
    if (cap && (start || s_q.in_frame))
    begin
      if (pre_v != 5'h00)
        pre_v = pre_v - 5'h01;
      else
      begin
        if (bit_v >= st && bit_v < st + wl)
        begin
          sh_v = {sh_v[30:0], syn[2]};
          word = sh_v << 6'(6'h20 - wl);
          if (bit_v == 6'(st + wl - 6'h01))
          begin
            if (slot_v == {1'b0, r[I_SLT][`F_SLOT_L +: 4]})
              s_d.left = word;
            if (slot_v == {1'b0, r[I_SLT][`F_SLOT_R +: 4]})
              s_d.right = word;
            if (slot_v == {1'b0, addr_offset})
              s_d.mono = word;
          end
        end
        if (bit_v == 6'(sl - 6'h01))
        begin
          bit_v = 6'h00;
          slot_v = slot_v + 5'h01;
        end
        else
          bit_v = bit_v + 6'h01;
      end
      s_d.pre = pre_v;
      s_d.slot = slot_v;
      s_d.bitc = bit_v;
      s_d.shreg = start ? {31'h0, sh_v[0] & (st == 6'h00 && pre_v == 5'h00 && s_q.pre == 5'h00 && r[I_RXF][`F_OFFSET +: 5] == 5'h00)} : sh_v;
    end
    // rate in use: programmed or detected
    s_d.rate_double = r[I_FRM][`F_AUTO_OFF] ? (r[I_FRM][`F_RATE +: 3] == `RATE_96K) : s_q.double_det;

    // shutdown pin handling
    if (syn[3])
    begin
      s_d.shdn_cnt = 21'h0;
      s_d.shutdown = 1'b0;
    end
    else if (r[I_SHDN][`F_SHUTDOWN_PIN_BEHAVIOUR +: 2] == 2'h1)
      s_d.shutdown = 1'b1;
    else if (s_q.shdn_cnt == shdn_limit(r[I_SHDN][`F_SDZ_TIME +: 2]))
      s_d.shutdown = 1'b1;
    else
      s_d.shdn_cnt = s_q.shdn_cnt + 21'h1;

    // fault hold-off with optional timed retry, a new event restarts it
    retry_on = {r[I_PROT][`F_OVERTEMP_RETRY], r[I_PROT][`F_OVERCURRENT_RETRY]};
    for (int f = 0; f < 2; f++)
    begin
      if ((f == 0) ? oc_event : ot_event)
      begin
        s_d.fault[f] = 1'b1;
        s_d.retry_cnt[f] = 23'h0;
      end
      else if (s_q.fault[f] && retry_on[f])
      begin
        if (s_q.retry_cnt[f] == 23'(RETRY_CYC - 1))
          s_d.fault[f] = 1'b0;
        s_d.retry_cnt[f] = s_q.retry_cnt[f] + 23'h1;
      end
      else
        s_d.retry_cnt[f] = 23'h0;
    end

    // volume ramp, one step per 1, 4 or 8 frames
    tick = r[I_SHDN][`F_RAMP +: 2];
    ramp_top = (tick == 2'h0) ? 3'h0 : (tick == 2'h1) ? 3'h3 : 3'h7;
    if (tick == 2'h3)
      s_d.volume = target_volume;
    else if (start)
    begin
      s_d.ramp_cnt = (s_q.ramp_cnt >= ramp_top) ? 3'h0 : s_q.ramp_cnt + 3'h1;
      if (s_q.ramp_cnt >= ramp_top && s_q.volume != target_volume)
        s_d.volume = (s_q.volume < target_volume) ? s_q.volume + 8'h01 : s_q.volume - 8'h01;
    end

    // sense width, reserved code passes full width
    unique case (r[I_FMT][`F_SENSE +: 2])
      2'h1: s_d.sense = {sense_in[15:4], 4'h0};
      2'h2: s_d.sense = {sense_in[15:8], 8'h00};
      default: s_d.sense = sense_in;
    endcase

    // record dc blocker cutoff, scaled for the 44.1 kHz family
    case (r[I_DCB][`F_HPF +: 3])
      3'h1: hz = 10'h002;
      3'h2: hz = 10'h032;
      3'h3: hz = 10'h064;
      3'h4: hz = 10'h0c8;
      3'h5: hz = 10'h190;
      3'h6: hz = 10'h320;
      default: hz = 10'h000;
    endcase
    hz_scaled = (20'(hz) * 20'(`HPF_SCALE_NUM)) >> `HPF_SCALE_SHIFT;
    s_d.hpf = r[I_FRM][`F_FAM] ? hz_scaled[9:0] : hz;
    s_d.spread = spread_req & ~r[I_FRM][`F_SYNC];
  end

  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
    begin
      s_q <= '0;
      s_q.regs <= {`RST_SLOTS, `RST_LIMIT, `RST_RXFMT, `RST_RXFRM,
                   `RST_FRAME, `RST_SHDN, `RST_PROT, `RST_DCBLK};
    end
    else
      s_q <= s_d;
  end

  // ********************
  // outputs from flip-flops, oc_threshold_pct through an adder
  // ********************
  assign cfg_rdata = s_q.rdata;
  assign audio = s_q.audio;
  assign audio_valid = s_q.audio_valid;
  assign rate_double = s_q.rate_double;
  assign amp_shutdown = s_q.shutdown;
  assign oc_fault = s_q.fault[0];
  assign ot_fault = s_q.fault[1];
  assign volume = s_q.volume;
  assign sense_out = s_q.sense;
  assign hpf_hz = s_q.hpf;
  assign thermal_foldback_on = s_q.regs[I_DCB][`F_TFB];
  assign feedback_from_sense = s_q.regs[I_PROT][`F_PFFB];
  assign extra_atten_18db = s_q.regs[I_PROT][`F_SAFE];
  // code times ten percent below nominal
  assign oc_threshold_pct = {s_q.regs[I_PROT][`F_OCTH +: 2], 3'h0} + {2'h0, s_q.regs[I_PROT][`F_OCTH +: 2], 1'b0};
  assign output_invert = s_q.regs[I_FRM][`F_INV];
  assign switching_lock = s_q.regs[I_FRM][`F_SYNC];
  assign spread_active = s_q.spread;
  assign rate_base_44k = s_q.regs[I_FRM][`F_FAM];
  assign addr_redetect = s_q.redetect;
  assign global_addr_on = s_q.regs[I_SHDN][`F_GBL];
  assign limiter_max_atten = s_q.regs[I_LIM][`F_LIM +: 4];
endmodule // amp_tdm_dev
`default_nettype wire

// *** amp_tdm_host.sv ***
// Purpose: host end that makes bit clock, frame sync and slot data
// Assumes: configuration inputs match the device registers
// Notes: data launched on the edge opposite the device capture edge
`timescale 1ns/1ns
`default_nettype none
`include "amp_tdm_consts.svh"
module amp_tdm_host #(
  parameter int HALF_DIV = `BCLK_PERIOD_NS / (2 * `CLK_PERIOD_NS),
  parameter int SLOTS = 8
) (
  input wire logic clk_sys, // system clock
  input wire logic rst_b, // async reset, active low
  tdm_link_if.host link, // serial audio to device
  input wire logic frame_pol, // 0 rising, 1 falling sync edge
  input wire logic [4:0] offset, // bit clocks before slot 0
  input wire logic cap_falling, // device captures on falling edge
  input wire logic justify_right, // right justify in slot
  input wire logic [1:0] receive_word_length, // word length code
  input wire logic [1:0] receive_slot_length, // slot length code
  input wire logic [3:0] slot_l, // left slot
  input wire logic [3:0] slot_r, // right slot
  input wire amp_tdm_pkg::sample_t left_in, // left sample
  input wire amp_tdm_pkg::sample_t right_in, // right sample
  output logic sample_taken // pulse when samples latched
);
  typedef struct packed {
    logic [7:0] div;
    logic bclk;
    logic fs;
    logic sd;
    logic fstart;
    logic [4:0] pre;
    logic [4:0] slot;
    logic [5:0] bitc;
    amp_tdm_pkg::sample_t left;
    amp_tdm_pkg::sample_t right;
    logic taken;
  } host_s;
  host_s s_q;
  host_s s_d;

  initial
  begin
    if (HALF_DIV < 3 || HALF_DIV > 255)
      $error("half bit period must be 3 to 255 clocks");
    if (SLOTS < 1 || SLOTS > 16)
      $error("slots per frame must be 1 to 16");
  end

  // ********************
  // divider and slot sequencer
  // ********************
  logic launch;
  logic [5:0] sl;
  logic [5:0] wl;
  logic [5:0] st;
  logic [4:0] pre_v;
  logic [4:0] slot_v;
  logic [5:0] bit_v;
  logic [5:0] k;
  amp_tdm_pkg::sample_t lv;
  amp_tdm_pkg::sample_t rv;
  amp_tdm_pkg::sample_t word;

  always_comb
  begin
    s_d = s_q;
    s_d.taken = 1'b0;
    launch = 1'b0;
    if (s_q.div == 8'(HALF_DIV - 1))
    begin
      s_d.div = 8'h00;
      s_d.bclk = ~s_q.bclk;
      launch = (~s_q.bclk) == cap_falling;
    end
    else
      s_d.div = s_q.div + 8'h01;
    sl = amp_tdm_pkg::slot_bits(receive_slot_length);
    wl = amp_tdm_pkg::word_bits(receive_word_length);
    if (wl > sl)
      wl = sl;
    st = justify_right ? 6'(sl - wl) : 6'h00;
    pre_v = s_q.fstart ? offset : s_q.pre;
    slot_v = s_q.fstart ? 5'h00 : s_q.slot;
    bit_v = s_q.fstart ? 6'h00 : s_q.bitc;
    lv = s_q.fstart ? left_in : s_q.left;
    rv = s_q.fstart ? right_in : s_q.right;
    k = 6'h00;
    word = 32'h0;
    if (launch)
    begin
      s_d.fs = s_q.fstart ^ frame_pol;
      s_d.fstart = 1'b0;
      s_d.sd = 1'b0;
      s_d.left = lv;
      s_d.right = rv;
      s_d.taken = s_q.fstart;
      if (pre_v != 5'h00)
        pre_v = pre_v - 5'h01;
      else
      begin
        if (bit_v >= st && bit_v < st + wl)
        begin
          k = 6'(bit_v - st);
          word = (slot_v == {1'b0, slot_l}) ? lv : (slot_v == {1'b0, slot_r}) ? rv : 32'h0;
          s_d.sd = word[5'(5'h1f - k[4:0])];
        end
        if (bit_v == 6'(sl - 6'h01))
        begin
          bit_v = 6'h00;
          s_d.fstart = slot_v == 5'(SLOTS - 1);
          slot_v = slot_v + 5'h01;
        end
        else
          bit_v = bit_v + 6'h01;
      end
      s_d.pre = pre_v;
      s_d.slot = slot_v;
      s_d.bitc = bit_v;
    end
  end

  // reset opens an idle frame, so either sync polarity gets a real first edge
  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
      s_q <= '0;
    else
      s_q <= s_d;
  end

  // link and user outputs straight from flip-flops
  assign link.serial_bit_clock = s_q.bclk;
  assign link.frame_sync = s_q.fs;
  assign link.serial_data = s_q.sd;
  assign sample_taken = s_q.taken;
endmodule // amp_tdm_host
`default_nettype wire

// *** amp_tdm_link_asserts.sv ***
// Purpose: wire checks on the serial audio link between the two ends
// Assumes: host divider at its default of four clocks per bit clock half
// Notes: framing inputs only change while reset is held
`timescale 1ns/1ns
`default_nettype none
module amp_tdm_link_asserts (
  input wire logic clk_sys, // system clock
  input wire logic rst_b, // reset, active low
  input wire logic serial_bit_clock, // bit clock
  input wire logic frame_sync, // frame sync
  input wire logic serial_data, // data
  input wire logic frame_pol, // 1 = sync active low
  input wire logic cap_falling, // capture on falling edge
  input wire logic [4:0] offset // bits before slot 0
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_b);
  // sync at its active level; a change into it starts a frame
  wire logic act = frame_sync != frame_pol;
  a_bclk_half: assert property ($changed(serial_bit_clock) |=>
    $stable(serial_bit_clock)[*3] ##1 $changed(serial_bit_clock)) else $error("bad bit clock");
  a_data_launch: assert property ($changed(serial_data) |->
    $changed(serial_bit_clock) && serial_bit_clock == cap_falling) else $error("data off edge");
  a_sync_launch: assert property ($changed(frame_sync) && act |->
    $changed(serial_bit_clock) && serial_bit_clock == cap_falling) else $error("sync off edge");
  a_sync_one_bit: assert property ($changed(frame_sync) && act |=> act[*7] ##1 !act)
    else $error("sync width wrong");
  a_offset_zero: assert property ($changed(frame_sync) && act && offset != 5'h00 |->
    !serial_data [*8]) else $error("offset bit not zero");
  a_reset_idle: assert property ($rose(rst_b) |-> !serial_bit_clock && !serial_data)
    else $error("link not idle after reset");
endmodule // amp_tdm_link_asserts
`default_nettype wire

// *** amp_tdm_pkg.sv ***
// Purpose: shared types and format decoders
// Assumes: nothing
// Notes: samples are 32 bits, left aligned
`default_nettype none
package amp_tdm_pkg;
  typedef logic [31:0] sample_t;
  typedef enum logic [1:0] {POL_ADDR, POL_LEFT, POL_RIGHT, POL_MIX} slot_policy_e;

  // slot length code to bits, reserved code treated as 32
  function automatic logic [5:0] slot_bits(input logic [1:0] c);
    case (c)
      2'h0: slot_bits = 6'h10;
      2'h1: slot_bits = 6'h18;
      default: slot_bits = 6'h20;
    endcase
  endfunction

  // word length code to bits
  function automatic logic [5:0] word_bits(input logic [1:0] c);
    case (c)
      2'h0: word_bits = 6'h10;
      2'h1: word_bits = 6'h14;
      2'h2: word_bits = 6'h18;
      default: word_bits = 6'h20;
    endcase
  endfunction
endpackage
`default_nettype wire

// *** pin_sync.sv ***
// Purpose: two flip-flop synchroniser for pins
// Assumes: inputs asynchronous to clk_sys
// Notes: only the second stage leaves this module
`timescale 1ns/1ns
`default_nettype none
module pin_sync #(
  parameter int W = 4,
  parameter logic [W-1:0] INIT = '0
) (
  input wire logic clk_sys, // system clock
  input wire logic rst_b, // async reset, active low
  input wire logic [W-1:0] din, // raw pins
  output logic [W-1:0] dout // synchronised pins
);
  typedef struct packed {
    logic [W-1:0] meta;
    logic [W-1:0] stable;
  } sync_s;
  sync_s s_q;
  sync_s s_d;

  initial
  begin
    if (W < 1)
      $error("pin_sync width must be positive");
  end

  // first stage feeds only the second
  always_comb
  begin
    s_d.meta = din;
    s_d.stable = s_q.meta;
  end

  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
      s_q <= {INIT, INIT};
    else
      s_q <= s_d;
  end

  assign dout = s_q.stable;
endmodule // pin_sync
`default_nettype wire

// *** tb_top.sv ***
// Purpose: host and amplifier ends joined over the link
// Assumes: default host divider and eight slots
// Notes: framing changes only while both ends sit in reset
`timescale 1ns/1ns
`default_nettype none
module tb_top;
  logic clk_sys = 0, rst_b = 0, cfg_wr = 0, shutdown_pin_b = 1, oc_event = 0, ot_event = 0;
  logic spread_req = 0, frame_pol = 0, cap_falling = 0, justify_right = 0, armed = 0, have = 0;
  logic [7:0] cfg_addr = 8'h05, cfg_wdata = 8'h00, target_volume = 8'h00, cfg_rdata, volume;
  logic [15:0] sense_in = 16'h0000, sense_out;
  logic [9:0] hpf_hz;
  logic [4:0] offset = 5'h01, oc_threshold_pct;
  logic [3:0] addr_offset = 4'h0, slot_l = 4'h0, slot_r = 4'h1, limiter_max_atten;
  logic [1:0] receive_word_length = 2'h2, receive_slot_length = 2'h2, pcy = 2'h0;
  logic audio_valid, rate_double, amp_shutdown, oc_fault, ot_fault, thermal_foldback_on;
  logic feedback_from_sense, extra_atten_18db, output_invert, switching_lock, spread_active;
  logic rate_base_44k, addr_redetect, global_addr_on, sample_taken;
  amp_tdm_pkg::sample_t audio, prev_exp, left_in = 32'h0, right_in = 32'h0, exp_q[$];
  int n_mismatch = 0, num_checks = 0, seed = 19, nb, wb;
  localparam int WB [4] = '{16, 20, 24, 32};
  localparam int SB [4] = '{16, 24, 32, 32};
  localparam logic [7:0] RV [8] = '{8'h41, 8'h00, 8'h20, 8'h09, 8'h02, 8'h0a, 8'h80, 8'h10};
  tdm_link_if lk();
  amp_tdm_host i_amp_tdm_host (.link(lk), .*);
  amp_tdm_dev #(.SHDN_CYC0(20), .SHDN_CYC1(40), .SHDN_CYC2(60), .SHDN_CYC3(200),
    .RETRY_CYC(50)) i_amp_tdm_dev (.link(lk), .*);
  amp_tdm_link_asserts i_amp_tdm_link_asserts (.serial_bit_clock(lk.serial_bit_clock),
    .frame_sync(lk.frame_sync), .serial_data(lk.serial_data), .*);
  // 50 MHz system clock
  initial forever #10 clk_sys = ~clk_sys;
  // keep only the top nb bits, as the receiver left-aligns a cut word
  function automatic amp_tdm_pkg::sample_t trim(amp_tdm_pkg::sample_t s);
    return s & ~(32'hffffffff >> nb);
  endfunction
  // sample the device should deliver for the current slot policy
  function automatic amp_tdm_pkg::sample_t expect_of(amp_tdm_pkg::sample_t l, r);
    logic [32:0] sum;
    sum = {l[31], trim(l)} + {r[31], trim(r)};
    case (pcy)
      2'h2: return trim(r);
      2'h3: return sum[32:1];
      default: return trim(l);
    endcase
  endfunction
  task automatic cmp8(input logic [7:0] g, input logic [7:0] e);
    num_checks++;
    if (g !== e)
      $display("unexpected at %0t: byte %h not %h", $time, g, e);
    n_mismatch += int'(g !== e);
  endtask
  task automatic cmp32(input logic [31:0] g, input logic [31:0] e);
    num_checks++;
    if (g !== e)
      $display("unexpected at %0t: sample %h not %h", $time, g, e);
    n_mismatch += int'(g !== e);
  endtask
  // strobe stays up between back-to-back writes; caller lowers it
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    cfg_wr <= 1'b1;
    cfg_addr <= a;
    cfg_wdata <= d;
    @(posedge clk_sys);
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    cfg_addr <= a;
    repeat (2) @(posedge clk_sys);
    cmp8(cfg_rdata, e);
  endtask
  task automatic rst();
    rst_b <= 1'b0;
    repeat (10) @(posedge clk_sys);
    rst_b <= 1'b1;
    @(posedge clk_sys);
  endtask
  task automatic summarize();
    if (n_mismatch == 0 && num_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  // a frame's samples come back at the start of the frame after it
  always @(posedge clk_sys)
    if (sample_taken)
    begin
      if (armed && have)
        exp_q.push_back(prev_exp);
      prev_exp = expect_of(left_in, right_in);
      have = armed;
      {left_in, right_in} <= {$random(seed), $random(seed)};
      {sense_in, target_volume} <= 24'($random(seed));
    end
  // delivered samples against the oldest note
  always @(posedge clk_sys)
    if (audio_valid && exp_q.size() > 0)
      cmp32(audio, exp_q.pop_front());
  // register defaults, odd places, then random framing sweeps
  initial
  begin
    rst();
    for (int i = 0; i < 8; i++)
      rd(8'h05 + 8'(i), RV[i]);
    rd(8'h04, 8'h00);
    cmp8(8'(hpf_hz), 8'h02);
    wr(8'h09, 8'hff);
    wr(8'h07, 8'h5d);
    cfg_wr <= 1'b0;
    @(posedge clk_sys);
    cmp8(8'(addr_redetect), 8'h01);
    @(posedge clk_sys);
    cmp8(8'(addr_redetect), 8'h00);
    rd(8'h07, 8'h5c);
    rd(8'h09, 8'h7f);
    oc_event <= 1'b1;
    @(posedge clk_sys);
    oc_event <= 1'b0;
    repeat (60) @(posedge clk_sys);
    cmp8({6'h00, ot_fault, oc_fault}, 8'h01);
    for (int k = 0; k < 5; k++)
    begin
      rst_b <= 1'b0;
      @(posedge clk_sys);
      armed <= 1'b0;
      have = 0;
      exp_q.delete();
      pcy <= 2'(k);
      {frame_pol, cap_falling, justify_right, offset, receive_word_length} <= 10'($random(seed));
      receive_slot_length <= 2'($unsigned($random(seed)) % 3);
      slot_l <= 4'($unsigned($random(seed)) % 8);
      @(posedge clk_sys);
      slot_r <= slot_l ^ {1'b0, 3'($random(seed)) | 3'h1};
      addr_offset <= slot_l;
      wb = WB[receive_word_length];
      nb = SB[receive_slot_length];
      // a word longer than its slot is only sent left-justified
      if (wb > nb)
        justify_right <= 1'b0;
      else
        nb = wb;
      rst();
      wr(8'h08, {7'h04, frame_pol});
      wr(8'h09, {1'b0, justify_right, offset, cap_falling});
      wr(8'h0a, {2'h0, pcy, receive_word_length, receive_slot_length});
      wr(8'h0c, {slot_r, slot_l});
      cfg_wr <= 1'b0;
      armed <= 1'b1;
      repeat (5) @(posedge sample_taken);
    end
    summarize();
  end
  // cut a hang short
  initial
  begin
    #2000000;
    n_mismatch++;
    summarize();
  end
endmodule // tb_top
`default_nettype wire

// *** tdm_link_if.sv ***
// Purpose: serial audio link between host and amplifier
// Assumes: host drives every wire
// Notes: no clocking block
`timescale 1ns/1ns
`default_nettype none
interface tdm_link_if;
  logic serial_bit_clock;
  logic frame_sync;
  logic serial_data;
  modport host (output serial_bit_clock, output frame_sync, output serial_data);
  modport dev (input serial_bit_clock, input frame_sync, input serial_data);
endinterface
`default_nettype wire
